// ### spfs_pkg.sv
// Purpose: constants and types for the stop mode and power-fail sequencer
// Assumes: 25 MHz system clock, 8 kHz ring oscillator sampled as a pin
// Notes:   register map is word aligned on an AXI4-Lite slave
package spfs_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ               = 25000000;
  localparam int unsigned RING_HZ              = 8000;
  localparam int unsigned WAKE_STEP_NS         = 125000;
  localparam int unsigned CRYSTAL_WARMUP_US    = 1000;
  localparam int unsigned CRYSTAL_WARMUP_CYC   = CRYSTAL_WARMUP_US * (CLK_HZ / 1000000);
  localparam int unsigned WARNING_PERSIST_US   = 100;
  localparam int unsigned WARNING_PERSIST_CYC  = WARNING_PERSIST_US * (CLK_HZ / 1000000);
  // counted after the two sync flops, so pin to release stays below 20
  localparam int unsigned EXT_RELEASE_CYC      = 16;
  localparam int unsigned WAKE_TIMER_W         = 16;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] POWER_CONTROL_REG_OFS = 8'h00;
  localparam logic [7:0] WAKE_INTERVAL_OFS     = 8'h04;
  localparam logic [7:0] STATUS_OFS            = 8'h08;
  localparam logic [7:0] STOP_REQUEST_OFS      = 8'h0c;

  // power_control_reg fields
  localparam int unsigned STOP_MONITOR_DISABLE_BIT = 0;
  localparam int unsigned PF_INT_ENABLE_BIT        = 1;
  localparam int unsigned MON_INTERVAL_LSB         = 2;
  localparam int unsigned WAKE_TIMER_EN_BIT        = 4;
  localparam logic [31:0] POWER_CONTROL_RESET      = 32'h0000_0001;

  // status fields
  localparam int unsigned POWER_FAIL_INT_FLAG_BIT = 0;
  localparam int unsigned STATE_LSB               = 4;

  localparam logic [15:0] RESTART_VECTOR = 16'h8000;
  localparam logic [15:0] NORMAL_VECTOR  = 16'h0000;

  // monitor interval codes: continuous, 2^11, 2^12, 2^13 ring clocks
  typedef enum logic [1:0] {
    MON_CONT = 2'b00,
    MON_P11  = 2'b01,
    MON_P12  = 2'b10,
    MON_P13  = 2'b11
  } spfs_mon_type;

  typedef enum logic [3:0] {
    ST_POR     = 4'b0000,
    ST_WARMUP  = 4'b0001,
    ST_RUN     = 4'b0010,
    ST_STOP    = 4'b0011,
    ST_SWARM   = 4'b0100,
    ST_PFRESET = 4'b0101,
    ST_CHECK   = 4'b0110,
    ST_EXTRST  = 4'b0111
  } spfs_state_type;

endpackage : spfs_pkg

// ### spfs_mon_if.sv
// Purpose: synchronised comparator and ring tick bundle
// Assumes: single system clock
// Notes:   driven by spfs_sync, read by the sequencer
`timescale 1ns/1ps
interface spfs_mon_if;
  logic above_por;
  logic above_rst;
  logic above_warn;
  logic ext_reset;
  logic io_wake;
  logic ring_tick;

  modport src (output above_por, above_rst, above_warn, ext_reset, io_wake, ring_tick);
  modport dst (input above_por, above_rst, above_warn, ext_reset, io_wake, ring_tick);
endinterface : spfs_mon_if

// ### spfs_sync.sv
// Purpose: two-flop synchronisers and ring oscillator edge tick
// Assumes: all inputs asynchronous to clk_i
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module spfs_sync (
  input  wire logic   clk_i,
  input  wire logic   rstn_i,
  input  wire logic   por_ok_i,
  input  wire logic   rst_ok_i,
  input  wire logic   warn_ok_i,
  input  wire logic   ext_rst_i,
  input  wire logic   io_wake_i,
  input  wire logic   ring_clk_i,
  spfs_mon_if.src     mon
);
  logic [5:0] meta;
  logic [5:0] sync;
  logic       ring_last;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  // two flop sync
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta      <= 6'h00;
      sync      <= 6'h00;
      ring_last <= 1'b0;
    end else begin
      meta      <= {ring_clk_i, io_wake_i, ext_rst_i, warn_ok_i, rst_ok_i, por_ok_i};
      sync      <= meta;
      ring_last <= sync[5];
    end
  end

  assign mon.above_por  = sync[0];
  assign mon.above_rst  = sync[1];
  assign mon.above_warn = sync[2];
  assign mon.ext_reset  = sync[3];
  assign mon.io_wake    = sync[4];
  // one pulse per ring oscillator rising edge
  assign mon.ring_tick  = sync[5] & ~ring_last;
endmodule : spfs_sync

// ### spfs_regs.sv
// Purpose: AXI4-Lite register slave for the sequencer
// Assumes: one write and one read outstanding at a time
// Notes:   unmapped addresses answer OKAY and read zero
`timescale 1ns/1ps
module spfs_regs
  import spfs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  input  wire logic [31:0] status_i,
  output logic [31:0]      ctrl_o,
  output logic [31:0]      wake_o,
  output logic             stop_req_o,
  output logic             flag_clr_o
);
  logic [7:0]  aw_q;
  logic        aw_have;
  logic [31:0] w_q;
  logic [3:0]  s_q;
  logic        w_have;
  logic        do_write;
  logic [31:0] rd_mux;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  assign do_write = aw_have & w_have & ~bvalid_o;
  assign rd_mux   = (araddr_i == POWER_CONTROL_REG_OFS) ? ctrl_o :
                    (araddr_i == WAKE_INTERVAL_OFS)     ? wake_o :
                    (araddr_i == STATUS_OFS)            ? status_i : 32'h0000_0000;

  // ----------------------------------------------------------------
  // write channel, address and data in either order
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      aw_q <= 8'h00; aw_have <= 1'b0; awready_o <= 1'b0;
      w_q <= 32'h0000_0000; s_q <= 4'h0; w_have <= 1'b0; wready_o <= 1'b0;
      bvalid_o <= 1'b0; bresp_o <= 2'b00;
      ctrl_o <= POWER_CONTROL_RESET; wake_o <= 32'h0000_0000;
      stop_req_o <= 1'b0; flag_clr_o <= 1'b0;
    end else begin
      awready_o  <= ~aw_have & ~awready_o & awvalid_i;
      wready_o   <= ~w_have & ~wready_o & wvalid_i;
      stop_req_o <= 1'b0;
      flag_clr_o <= 1'b0;
      if (awvalid_i & awready_o) begin
        aw_q <= awaddr_i; aw_have <= 1'b1;
      end
      if (wvalid_i & wready_o) begin
        w_q <= wdata_i; s_q <= wstrb_i; w_have <= 1'b1;
      end
      if (do_write) begin
        aw_have <= 1'b0; w_have <= 1'b0; bvalid_o <= 1'b1;
        if (aw_q == POWER_CONTROL_REG_OFS) ctrl_o <= merge(ctrl_o, w_q, s_q);
        if (aw_q == WAKE_INTERVAL_OFS) wake_o <= merge(wake_o, w_q, s_q);
        // stop request when bit 0 written as one
        if (aw_q == STOP_REQUEST_OFS) stop_req_o <= s_q[0] & w_q[0];
        // flag cleared by writing one to it
        if (aw_q == STATUS_OFS) flag_clr_o <= s_q[0] & w_q[POWER_FAIL_INT_FLAG_BIT];
      end else if (bvalid_o & bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      arready_o <= 1'b0; rvalid_o <= 1'b0; rdata_o <= 32'h0000_0000; rresp_o <= 2'b00;
    end else begin
      arready_o <= ~arready_o & ~rvalid_o & arvalid_i;
      if (arvalid_i & arready_o) begin
        rvalid_o <= 1'b1;
        rdata_o  <= rd_mux;
      end else if (rvalid_o & rready_i) begin
        rvalid_o <= 1'b0;
      end
    end
  end
endmodule : spfs_regs

// ### spfs_top.sv
// Purpose: stop mode, wake-up and power-fail reset sequencer
// Assumes: comparator levels and ring clock arrive asynchronously
// Notes:   crystal warm-up and warning persistence in system clocks
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps

// Behaviour
// - stop halts cpu, state kept
// - wake on io, warning, power-fail reset
// - ring-clocked wake timer, 125us steps
// - monitor on outside stop, except below power-on and in periodic power-fail reset
// - stop monitor disable resets to one
// - disabled monitor sees only power-on level
// - monitor re-enabled before stop exit
// - hold cpu reset during crystal warm-up, cpu halted instead in stop-exit warm-up
// - warning flag after persistence time
// - below reset level: reset, regulator off
// - recovery waits warm-up, restarts at 8000h
// - periodic interval continuous or 2^11..2^13
// - check spans two ring cycles plus one
// - third period good then restart 8000h
// - external reset keeps supplies, fast release
// - stop keeps regulator off, ignores dips only with monitor disabled
// - warning in stop warms up, exits
// - below power-on: everything off
module spfs_top
  import spfs_pkg::*;
#(
  parameter int unsigned WARMUP_CYC  = CRYSTAL_WARMUP_CYC,
  parameter int unsigned PERSIST_CYC = WARNING_PERSIST_CYC
)(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        por_ok_i,
  input  wire logic        rst_ok_i,
  input  wire logic        warn_ok_i,
  input  wire logic        ext_rst_i,
  input  wire logic        io_wake_i,
  input  wire logic        ring_clk_i,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  output logic             cpu_reset_o,
  output logic             cpu_halt_o,
  output logic             regulator_en_o,
  output logic             crystal_en_o,
  output logic             monitor_en_o,
  output logic             sram_retain_o,
  output logic             power_fail_int_o,
  output logic [15:0]      start_vector_o
);
  spfs_mon_if mon ();

  spfs_state_type state;
  spfs_state_type next_state;
  logic [31:0] ctrl;
  logic [31:0] wake;
  logic [31:0] status;
  logic        stop_req;
  logic        flag_clr;
  logic        power_fail_int_flag;
  logic [31:0] cnt;
  logic [13:0] ring_cnt;
  logic [WAKE_TIMER_W-1:0] wake_cnt;
  logic [1:0]  chk_cnt;
  logic        pf_boot;

  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  spfs_sync u_sync (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .por_ok_i   (por_ok_i),
    .rst_ok_i   (rst_ok_i),
    .warn_ok_i  (warn_ok_i),
    .ext_rst_i  (ext_rst_i),
    .io_wake_i  (io_wake_i),
    .ring_clk_i (ring_clk_i),
    .mon        (mon.src)
  );

  spfs_regs u_regs (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .awaddr_i   (awaddr_i),
    .awvalid_i  (awvalid_i),
    .awready_o  (awready_o),
    .wdata_i    (wdata_i),
    .wstrb_i    (wstrb_i),
    .wvalid_i   (wvalid_i),
    .wready_o   (wready_o),
    .bresp_o    (bresp_o),
    .bvalid_o   (bvalid_o),
    .bready_i   (bready_i),
    .araddr_i   (araddr_i),
    .arvalid_i  (arvalid_i),
    .arready_o  (arready_o),
    .rdata_o    (rdata_o),
    .rresp_o    (rresp_o),
    .rvalid_o   (rvalid_o),
    .rready_i   (rready_i),
    .status_i   (status),
    .ctrl_o     (ctrl),
    .wake_o     (wake),
    .stop_req_o (stop_req),
    .flag_clr_o (flag_clr)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic         stop_monitor_disable;
  logic         pf_int_en;
  spfs_mon_type mon_interval;
  logic         wake_timer_en;
  logic         in_stop;
  logic         mon_active;
  logic         warn_level;
  logic         warmup_done;
  logic         persist_done;
  logic         period_hit;
  logic         wake_hit;
  logic         ext_done;

  assign stop_monitor_disable = ctrl[STOP_MONITOR_DISABLE_BIT];
  assign pf_int_en            = ctrl[PF_INT_ENABLE_BIT];
  assign mon_interval         = spfs_mon_type'(ctrl[MON_INTERVAL_LSB +: 2]);
  assign wake_timer_en        = ctrl[WAKE_TIMER_EN_BIT];
  assign in_stop              = (state == ST_STOP);
  // monitor on unless stop and disabled
  // disabled monitor ignores warn and reset
  assign mon_active  = ~in_stop | ~stop_monitor_disable;
  assign warn_level  = mon.above_rst & ~mon.above_warn;
  assign warmup_done = (cnt >= WARMUP_CYC - 1);
  assign persist_done = (cnt >= PERSIST_CYC - 1);
  assign ext_done    = (cnt >= EXT_RELEASE_CYC - 1);
  assign period_hit  = (mon_interval == MON_CONT) ? 1'b1 :
                       (mon_interval == MON_P11)  ? (ring_cnt[10:0] == 11'h7ff) :
                       (mon_interval == MON_P12)  ? (ring_cnt[11:0] == 12'hfff) :
                                                     (ring_cnt[12:0] == 13'h1fff);
  assign wake_hit    = wake_timer_en & mon.ring_tick &
                       (wake_cnt == wake[WAKE_TIMER_W-1:0]) & (wake[WAKE_TIMER_W-1:0] != '0);
  assign status      = {24'h000000, state, 3'b000, power_fail_int_flag};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (!mon.above_por) begin
      next_state = ST_POR;
    end else begin
      unique case (state)
        ST_POR:     next_state = ST_WARMUP;
        ST_WARMUP:  if (warmup_done && mon.above_rst) next_state = ST_RUN;
        ST_RUN: begin
          if (!mon.above_rst) next_state = ST_PFRESET;
          else if (mon.ext_reset) next_state = ST_EXTRST;
          else if (stop_req) next_state = ST_STOP;
        end
        ST_STOP: begin
          if (mon_active && !mon.above_rst) next_state = ST_PFRESET;
          else if ((mon_active && warn_level) || mon.io_wake || wake_hit)
            next_state = ST_SWARM;
        end
        ST_SWARM: begin
          if (!mon.above_rst) next_state = ST_PFRESET;
          else if (warmup_done) next_state = ST_RUN;
        end
        ST_PFRESET: if (mon.ring_tick && period_hit) next_state = ST_CHECK;
        ST_CHECK: begin
          if (mon.ring_tick && !mon.above_rst) next_state = ST_PFRESET;
          // third period good, warm and restart
          else if (mon.ring_tick && chk_cnt == 2'd2) next_state = ST_WARMUP;
        end
        ST_EXTRST:  if (ext_done) next_state = ST_RUN;
        default:    next_state = ST_POR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state, counters and flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= ST_POR;
      cnt <= 32'h0000_0000;
      ring_cnt <= 14'h0000;
      wake_cnt <= '0;
      chk_cnt <= 2'd0;
      pf_boot <= 1'b0;
      power_fail_int_flag <= 1'b0;
    end else begin
      state <= next_state;
      // external reset counts from source removal
      if (next_state != state || (state == ST_EXTRST && mon.ext_reset) ||
          (state == ST_RUN && !warn_level)) begin
        cnt <= 32'h0000_0000;
      end else if (cnt != 32'hffff_ffff) begin
        cnt <= cnt + 32'h0000_0001;
      end
      if (state == ST_PFRESET && mon.ring_tick) ring_cnt <= ring_cnt + 14'h0001;
      else if (state != ST_PFRESET) ring_cnt <= 14'h0000;
      if (state == ST_CHECK && mon.ring_tick) chk_cnt <= chk_cnt + 2'd1;
      else if (state != ST_CHECK) chk_cnt <= 2'd0;
      if (state == ST_STOP && mon.ring_tick) wake_cnt <= wake_cnt + 1'b1;
      else if (state != ST_STOP) wake_cnt <= '0;
      if (state == ST_PFRESET) pf_boot <= 1'b1;
      else if (state == ST_POR) pf_boot <= 1'b0;
      else if (state == ST_RUN && next_state == ST_RUN) pf_boot <= 1'b0;
      // set after persistence, set beats clear
      // warning at stop exit sets flag
      if ((state == ST_RUN && warn_level && persist_done) ||
          (state == ST_SWARM && next_state == ST_RUN && warn_level)) begin
        power_fail_int_flag <= 1'b1;
      end else if (flag_clr) begin
        power_fail_int_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cpu_reset_o <= 1'b1;
      cpu_halt_o <= 1'b0;
      regulator_en_o <= 1'b0;
      crystal_en_o <= 1'b0;
      monitor_en_o <= 1'b0;
      sram_retain_o <= 1'b0;
      power_fail_int_o <= 1'b0;
      start_vector_o <= NORMAL_VECTOR;
    end else begin
      cpu_reset_o <= (next_state != ST_RUN) && (next_state != ST_STOP) &&
                     (next_state != ST_SWARM);
      cpu_halt_o <= (next_state == ST_STOP) || (next_state == ST_SWARM);
      // stop keeps regulator and crystal off
      regulator_en_o <= (next_state == ST_WARMUP) || (next_state == ST_RUN) ||
                        (next_state == ST_SWARM) || (next_state == ST_EXTRST);
      crystal_en_o <= (next_state == ST_WARMUP) || (next_state == ST_RUN) ||
                      (next_state == ST_SWARM) || (next_state == ST_EXTRST);
      // default disable turns monitor off in stop
      monitor_en_o <= (next_state == ST_STOP) ? ~stop_monitor_disable :
                      (next_state == ST_PFRESET) ? (mon_interval == MON_CONT) :
                      (next_state != ST_POR);
      sram_retain_o <= (next_state == ST_STOP) || (next_state == ST_SWARM) ||
                       (next_state == ST_PFRESET) || (next_state == ST_CHECK);
      power_fail_int_o <= power_fail_int_flag & pf_int_en;
      start_vector_o <= pf_boot ? RESTART_VECTOR : NORMAL_VECTOR;
    end
  end
endmodule : spfs_top

// ### spfs_chk.sv
// Purpose: port checks for the stop mode and power-fail sequencer
// Assumes: bound to spfs_top, warm-up count handed down
// Notes:   sequencer sees raw comparator inputs two cycles late
`timescale 1ns/1ps
module spfs_chk #(
  parameter int unsigned WARMUP_CYC = 20
)(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic por_ok_i,
  input wire logic rst_ok_i,
  input wire logic warn_ok_i,
  input wire logic ext_rst_i,
  input wire logic io_wake_i,
  input wire logic cpu_reset_o,
  input wire logic cpu_halt_o,
  input wire logic regulator_en_o,
  input wire logic crystal_en_o,
  input wire logic monitor_en_o,
  input wire logic sram_retain_o
);
  // ----------------------------------------------------------------
  // helper and properties
  // ----------------------------------------------------------------
  logic [15:0] xcnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // saturates so long runs never wrap back below the warm-up count
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !crystal_en_o) xcnt <= 16'h0000;
    else if (xcnt != 16'hffff) xcnt <= xcnt + 16'h0001;
  end
  property p_halt; cpu_halt_o |-> !cpu_reset_o && sram_retain_o; endproperty
  a_halt: assert property (p_halt) else $error("halted cpu reset or sram dropped");
  property p_run_mon; !cpu_halt_o && !cpu_reset_o |-> monitor_en_o; endproperty
  a_run_mon: assert property (p_run_mon) else $error("monitor off while running");
  property p_pf_off; cpu_reset_o && sram_retain_o |-> !regulator_en_o && !crystal_en_o; endproperty
  a_pf_off: assert property (p_pf_off) else $error("supplies on in power-fail reset");
  property p_warm; $fell(cpu_reset_o) |-> xcnt >= WARMUP_CYC - 1; endproperty
  a_warm: assert property (p_warm) else $error("cpu released before crystal warm-up");
  property p_ext_rel; $fell(ext_rst_i) && regulator_en_o |-> ##[1:19] !cpu_reset_o; endproperty
  a_ext_rel: assert property (p_ext_rel) else $error("late release after external reset");
  property p_por; !por_ok_i [*6] |-> cpu_reset_o && !regulator_en_o && !monitor_en_o; endproperty
  a_por: assert property (p_por) else $error("activity below power-on level");
  property p_mon_off; cpu_halt_o && !monitor_en_o && por_ok_i |=> !cpu_reset_o; endproperty
  a_mon_off: assert property (p_mon_off) else $error("reset with monitor disabled");
  property p_io; (cpu_halt_o && io_wake_i) [*3] |-> ##[0:4] crystal_en_o; endproperty
  a_io: assert property (p_io) else $error("io wake ignored in stop");
  property p_warn;
    (cpu_halt_o && monitor_en_o && !warn_ok_i && rst_ok_i) [*3] |-> ##[0:4] crystal_en_o;
  endproperty
  a_warn: assert property (p_warn) else $error("warning ignored in stop");
endmodule : spfs_chk
bind spfs_top spfs_chk #(.WARMUP_CYC(WARMUP_CYC)) u_chk (.*);

// ### spfs_supply.sv
// Purpose: supply comparators and free-running ring oscillator
// Assumes: level 0 below power-on, 1 below reset, 2 below warning, 3 good
// Notes:   ring period shortened in sim to keep long intervals affordable
`timescale 1ns/1ps
module spfs_supply #(
  parameter int RING_HALF_NS = 200
)(
  input  wire logic [1:0] level_i,
  output logic            por_ok_o,
  output logic            rst_ok_o,
  output logic            warn_ok_o,
  output logic            ring_clk_o
);
  // ----------------------------------------------------------------
  // comparators and ring
  // ----------------------------------------------------------------
  assign por_ok_o  = level_i >= 2'h1;
  assign rst_ok_o  = level_i >= 2'h2;
  assign warn_ok_o = level_i == 2'h3;
  initial begin
    ring_clk_o = 1'b0;
    forever #(RING_HALF_NS) ring_clk_o = ~ring_clk_o;
  end
endmodule : spfs_supply

// ### tb.sv
// Purpose: register-driven tests of the sequencer
// Assumes: ring period of ten system clocks, short warm-up counts
// Notes:   supply level driven through the comparator model
`timescale 1ns/1ps
module tb;
  import spfs_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam int WARM = 20;
  localparam int PERS = 5;
  logic        clk_i, por_ok_i, rst_ok_i, warn_ok_i, ring_clk_i;
  logic        rstn_i = 1'b0, ext_rst_i = 1'b0, io_wake_i = 1'b0;
  logic        awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0;
  logic        arvalid_i = 1'b0, rready_i = 1'b0;
  logic [7:0]  awaddr_i = 8'h00, araddr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, d;
  logic [3:0]  wstrb_i = 4'hf;
  logic [1:0]  level = 2'h3, bresp_o, rresp_o;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o, cpu_reset_o, cpu_halt_o;
  logic        regulator_en_o, crystal_en_o, monitor_en_o, sram_retain_o, power_fail_int_o;
  logic [31:0] rdata_o;
  logic [15:0] start_vector_o;
  int          fail_count = 0, num_checks = 0, cyc = 0, n;
  spfs_top #(.WARMUP_CYC(WARM), .PERSIST_CYC(PERS)) u_dut (.*);
  spfs_supply #(.RING_HALF_NS(200)) u_sup (.level_i(level), .por_ok_o(por_ok_i),
    .rst_ok_o(rst_ok_i), .warn_ok_o(warn_ok_i), .ring_clk_o(ring_clk_i));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    {awaddr_i, wdata_i, awvalid_i, wvalid_i, bready_i} <= {a, v, 3'b111};
    forever begin
      @(posedge clk_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
      if (bvalid_o) break;
    end
    chk(32'(bresp_o), 32'h0);
    bready_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    {araddr_i, arvalid_i, rready_i} <= {a, 2'b11};
    forever begin
      @(posedge clk_i);
      if (arready_o) arvalid_i <= 1'b0;
      if (rvalid_o) break;
    end
    v = rdata_o;
    chk(32'(rresp_o), 32'h0);
    rready_i <= 1'b0;
  endtask : rd
  // no bound here: the cycle ceiling below ends any hang
  task automatic wt(input bit sel, input logic v, output int k);
    k = 0;
    while ((sel ? cpu_halt_o : cpu_reset_o) !== v) begin
      @(posedge clk_i);
      k++;
    end
  endtask : wt
  task automatic print_verdict;
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    wt(0, 1'b0, n);
    rd(8'h00, d);
    chk(d, 32'h1);
    rd(8'h20, d);
    chk(d, 32'h0);
    wr(8'h00, 32'h2);
    level <= 2'h2;
    repeat (3) @(posedge clk_i);
    level <= 2'h3;
    repeat (10) @(posedge clk_i);
    chk(32'(power_fail_int_o), 32'h0);
    level <= 2'h2;
    repeat (PERS) @(posedge clk_i);
    chk(32'(power_fail_int_o), 32'h0);
    repeat (8) @(posedge clk_i);
    chk(32'(power_fail_int_o), 32'h1);
    level <= 2'h3;
    wr(8'h08, 32'h1);
    rd(8'h08, d);
    chk(d & 32'h1, 32'h0);
    wr(8'h00, 32'h1);
    wr(8'h0c, 32'h1);
    wt(1, 1'b1, n);
    level <= 2'h1;
    repeat (40) @(posedge clk_i);
    chk(32'({cpu_halt_o, cpu_reset_o, regulator_en_o, monitor_en_o}), 32'h8);
    level <= 2'h3;
    io_wake_i <= 1'b1;
    wt(1, 1'b0, n);
    io_wake_i <= 1'b0;
    chk(32'({cpu_reset_o, monitor_en_o}), 32'h1);
    wr(8'h00, 32'h2);
    wr(8'h0c, 32'h1);
    wt(1, 1'b1, n);
    level <= 2'h2;
    wt(1, 1'b0, n);
    repeat (2) @(posedge clk_i);
    chk(32'(power_fail_int_o), 32'h1);
    level <= 2'h3;
    wr(8'h08, 32'h1);
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h11);
    wr(8'h0c, 32'h1);
    wt(1, 1'b1, n);
    wt(1, 1'b0, n);
    chk(32'(n >= 50 && n <= 70), 32'h1);
    for (int c = 0; c < 2; c++) begin
      wr(8'h00, 32'(c << 2));
      level <= 2'h1;
      wt(0, 1'b1, n);
      repeat (2) @(posedge clk_i);
      chk(32'({regulator_en_o, crystal_en_o, sram_retain_o}), 32'h1);
      level <= 2'h3;
      wt(0, 1'b0, n);
      chk(32'(n >= (c ? 20460 : 30)), 32'h1);
      chk(32'(start_vector_o), 32'h8000);
    end
    ext_rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(32'({cpu_reset_o, regulator_en_o, crystal_en_o, monitor_en_o}), 32'hf);
    ext_rst_i <= 1'b0;
    wt(0, 1'b0, n);
    chk(32'(n <= 19), 32'h1);
    chk(32'(start_vector_o), 32'h0);
    level <= 2'h0;
    repeat (8) @(posedge clk_i);
    chk(32'({cpu_reset_o, regulator_en_o, crystal_en_o, monitor_en_o}), 32'h8);
    level <= 2'h3;
    wt(0, 1'b0, n);
    chk(32'(n >= WARM), 32'h1);
    print_verdict();
  end
endmodule : tb
